/* File: core/ubrg_pkg.sv */
// package for the serial-port baud rate generator
// assumes an 8-bit register port clocked by the system oscillator
package ubrg_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] RCS_OFFS    = 8'h18; // receive control/status
    localparam logic [7:0] TCS_OFFS    = 8'h98; // transmit control/status
    localparam logic [7:0] DIV_OFFS    = 8'h99; // baud divisor

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RCS_RST     = 8'h00; // receive control reset
    localparam logic [7:0] TCS_RST     = 8'h02; // transmit control reset
    localparam logic [7:0] DIV_RST     = 8'h00; // divisor reset

    // ------------------------------------------------------------------
    // transmit and receive control fields
    // ------------------------------------------------------------------
    localparam int TCS_MASTER_BIT      = 7;     // clock source: master
    localparam int TCS_SYNC_BIT        = 4;     // synchronous mode select
    localparam int TCS_UNUSED_BIT      = 3;     // unimplemented, reads 0
    localparam int TCS_HSPEED_BIT      = 2;     // high_speed_select
    localparam logic [7:0] TCS_WMASK   = 8'hF5; // writable bits
    localparam logic [7:0] RCS_WMASK   = 8'hF9; // writable bits
    localparam int RCS_ENABLE_BIT      = 7;     // serial port enable

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int INSTR_DIV           = 4;     // instruction clock ratio
    localparam int SLOW_RATIO          = 16;    // x64 sample / 4
    localparam int FAST_RATIO          = 4;     // x16 sample / 4
    localparam int SYNC_RATIO          = 1;     // /4 sync bit clock
    localparam int VOTE_SAMPLES        = 3;     // samples per vote

    // ------------------------------------------------------------------
    // rate generator modes and status carrier
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        UBRG_ASYNC_SLOW,
        UBRG_ASYNC_FAST,
        UBRG_SYNC_MASTER,
        UBRG_SYNC_SLAVE
    } ubrg_mode_e;

    typedef struct packed {
        logic       sample_tick;  // sampling clock tick (async) or bit clock (sync master)
        logic       bit_tick;     // one bit period elapsed
        logic       rx_level;     // voted receive level
    } ubrg_out_s;

endpackage : ubrg_pkg

/* File: core/ubrg_timer.sv */
// free-running reload timer producing one tick per (load+1) counts
// assumes a one-cycle enable strobe and synchronous active-low reset
`timescale 1ns/1ps
module ubrg_timer #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    // control
    input  wire logic             count_en,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] load,
    // result
    output logic                  tick
);
    initial begin
        if (WIDTH < 1) $error("ubrg_timer: WIDTH must be positive");
    end

    logic [WIDTH-1:0] cnt_r;     // counts down to zero

    // ------------------------------------------------------------------
    // down counter, reload on zero
    // ------------------------------------------------------------------
    assign tick = count_en && (cnt_r == '0);

    // count down; a clear forces a reload from the new value
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (clear) begin
            cnt_r <= load;
        end else if (tick) begin
            cnt_r <= load;
        end else if (count_en) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule : ubrg_timer

/* File: core/ubrg_top.sv */
// baud rate generator top: registers, prescale, timer, sampling
// assumes ref_clk is the oscillator and rx pin is asynchronous
//
// What this block does
// - one 8-bit generator serves both modes
// - divisor sets free-running 8-bit timer period
// - high_speed_select also sets asynchronous rate
// - synchronous mode ignores high_speed_select
// - async slow rate is osc/(64(X+1))
// - async fast rate is osc/(16(X+1))
// - synchronous rate is osc/(4(X+1))
// - divisor is unsigned 0 through 255
// - formulas apply to master; slave clocked externally
// - divisor write clears the generator timer
// - receive pin sampled three times, majority vote
// - async output samples at x16 or x64
// - mode bit zero async, one synchronous
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module ubrg_top #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // status from neighbours
    input  wire logic       tx_shift_empty,
    // pins and link side
    input  wire logic       receive_data_pin,
    // outputs to transmitter and receiver
    output ubrg_pkg::ubrg_out_s gen_out,
    output logic            sync_mode,
    output logic            sync_master
);
    initial begin
        if (DIV_W != 8) $error("ubrg_top: divisor must be 8 bits");
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]       tcs_r;        // transmit control/status
    logic [7:0]       rcs_r;        // receive control/status
    logic [DIV_W-1:0] div_r;        // baud divisor
    logic [7:0]       rdata_r;      // read data, one cycle late
    logic             div_wr;       // divisor write this cycle
    ubrg_pkg::ubrg_mode_e mode;     // decoded mode

    assign div_wr = reg_wr && (reg_addr == ubrg_pkg::DIV_OFFS);

    // transmit control writes; status bit 1 mirrors shifter state
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tcs_r <= ubrg_pkg::TCS_RST;
        end else if (reg_wr && reg_addr == ubrg_pkg::TCS_OFFS) begin
            tcs_r <= (reg_wdata & ubrg_pkg::TCS_WMASK)
                   | {6'h00, tx_shift_empty, 1'b0};
        end else begin
            tcs_r <= {tcs_r[7:2], tx_shift_empty, tcs_r[0]};
        end
    end

    // receive control writes; error flags belong to the receiver
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rcs_r <= ubrg_pkg::RCS_RST;
        end else if (reg_wr && reg_addr == ubrg_pkg::RCS_OFFS) begin
            rcs_r <= reg_wdata & ubrg_pkg::RCS_WMASK;
        end
    end

    // divisor register, full unsigned range 0..255
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            div_r <= ubrg_pkg::DIV_RST;
        end else if (div_wr) begin
            div_r <= reg_wdata;
        end
    end

    // read mux; unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ubrg_pkg::TCS_OFFS: rdata_r <= tcs_r;
                ubrg_pkg::RCS_OFFS: rdata_r <= rcs_r;
                ubrg_pkg::DIV_OFFS: rdata_r <= div_r;
                default:            rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    // bit 4 picks sync; in sync the speed bit is not looked at
    always_comb begin
        if (!tcs_r[ubrg_pkg::TCS_SYNC_BIT]) begin
            mode = tcs_r[ubrg_pkg::TCS_HSPEED_BIT]
                 ? ubrg_pkg::UBRG_ASYNC_FAST
                 : ubrg_pkg::UBRG_ASYNC_SLOW;
        end else begin
            mode = tcs_r[ubrg_pkg::TCS_MASTER_BIT]
                 ? ubrg_pkg::UBRG_SYNC_MASTER
                 : ubrg_pkg::UBRG_SYNC_SLAVE;
        end
    end

    assign sync_mode   = tcs_r[ubrg_pkg::TCS_SYNC_BIT];
    assign sync_master = (mode == ubrg_pkg::UBRG_SYNC_MASTER);

    // ------------------------------------------------------------------
    // instruction clock prescaler (osc / 4)
    // ------------------------------------------------------------------
    logic [1:0] pre_r;          // oscillator phase counter
    logic       instr_tick;     // one pulse per instruction cycle

    assign instr_tick = (pre_r == 2'(ubrg_pkg::INSTR_DIV - 1));

    // phase counter restarts with the timer on a divisor write
    always_ff @(posedge ref_clk) begin
        if (!rst_b || div_wr) begin
            pre_r <= 2'h0;
        end else begin
            pre_r <= pre_r + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // 8-bit free-running timer
    // ------------------------------------------------------------------
    logic timer_tick;           // one per (X+1) instruction cycles

    ubrg_timer #(
        .WIDTH    (DIV_W)
    ) u_timer (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .count_en (instr_tick),
        .clear    (div_wr),
        // on a divisor write reload from the new value, not the old one
        .load     (div_wr ? reg_wdata : div_r),
        .tick     (timer_tick)
    );

    // ------------------------------------------------------------------
    // post-divider to sample and bit ticks
    // ------------------------------------------------------------------
    logic [3:0] post_r;         // counts timer ticks within a sample
    logic [3:0] post_last;      // terminal count for this mode
    logic       sample_tick;    // x16 / x64 sample, or sync bit
    logic [3:0] smp_cnt_r;      // 16 samples make one bit
    logic       bit_tick;

    // slow: 16 timer ticks -> osc/(64(X+1)) sampling
    always_comb begin
        case (mode)
            ubrg_pkg::UBRG_ASYNC_SLOW:
                post_last = 4'(ubrg_pkg::SLOW_RATIO - 1);
            ubrg_pkg::UBRG_ASYNC_FAST:
                post_last = 4'(ubrg_pkg::FAST_RATIO - 1);
            ubrg_pkg::UBRG_SYNC_MASTER:
                post_last = 4'(ubrg_pkg::SYNC_RATIO - 1);
            default:
                post_last = 4'h0;
        endcase
    end

    // post-divider; cleared with the timer
    always_ff @(posedge ref_clk) begin
        if (!rst_b || div_wr) begin
            post_r <= 4'h0;
        end else if (timer_tick) begin
            post_r <= (post_r >= post_last) ? 4'h0 : post_r + 4'h1;
        end
    end

    // slave mode: no internal bit clock
    assign sample_tick = timer_tick && (post_r >= post_last)
                       && (mode != ubrg_pkg::UBRG_SYNC_SLAVE);

    // sixteen samples per bit in async, one per bit in sync
    always_ff @(posedge ref_clk) begin
        if (!rst_b || div_wr) begin
            smp_cnt_r <= 4'h0;
        end else if (sample_tick) begin
            smp_cnt_r <= smp_cnt_r + 4'h1;
        end
    end

    assign bit_tick = sample_tick && (sync_mode || smp_cnt_r == 4'hF);

    // ------------------------------------------------------------------
    // receive pin synchroniser and majority vote
    // ------------------------------------------------------------------
    logic rx_s1_r;              // first synchroniser stage
    logic rx_s2_r;              // second synchroniser stage
    logic rx_level;

    // two-flop synchroniser, idle high
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= receive_data_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    ubrg_vote u_vote (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .sample_en (sample_tick),
        .line_in   (rx_s2_r),
        .level     (rx_level)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic [2:0] out_r;          // registered tick/level outputs

    // outputs registered; ticks lag their cause by one cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            out_r <= 3'b001;
        end else begin
            out_r <= {sample_tick, bit_tick, rx_level};
        end
    end

    assign gen_out.sample_tick = out_r[2];
    assign gen_out.bit_tick    = out_r[1];
    assign gen_out.rx_level    = out_r[0];
endmodule : ubrg_top

/* File: core/ubrg_vote.sv */
// three-sample majority detector on a synchronised line level
// assumes the input already passed a two-flop synchroniser
`timescale 1ns/1ps
module ubrg_vote (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // sampling
    input  wire logic sample_en,
    input  wire logic line_in,
    // result
    output logic      level
);
    logic [2:0] smp_r;     // last three samples
    logic       level_r;   // registered vote

    // ------------------------------------------------------------------
    // shift samples and vote
    // ------------------------------------------------------------------
    // idle line is high, so samples start high
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            smp_r <= 3'h7;
        end else if (sample_en) begin
            smp_r <= {smp_r[1:0], line_in};
        end
    end

    // two of three decide the level
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            level_r <= 1'b1;
        end else begin
            level_r <= (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2])
                     | (smp_r[0] & smp_r[2]);
        end
    end

    assign level = level_r;
endmodule : ubrg_vote

/* File: tb/tb_ubrg_top.sv */
// testbench: registers, tick spacing per mode, restart, vote
// assumes the checker binds itself; clock 50 MHz
`timescale 1ns/1ps
module tb_ubrg_top;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic       ref_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       tx_shift_empty = 1'b1;
    logic       receive_data_pin = 1'b1;
    logic       sync_mode;
    logic       sync_master;
    ubrg_pkg::ubrg_out_s gen_out;
    int         mismatches = 0;
    int         n_checks = 0;
    int         seed = 83844;
    int         c;
    int         n;
    logic [7:0] d;
    logic [7:0] tab [4] = '{8'h00, 8'h04, 8'h90, 8'h94};
    always #10 ref_clk = ~ref_clk;
    ubrg_top dut (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .tx_shift_empty(tx_shift_empty),
        .receive_data_pin(receive_data_pin),
        .gen_out(gen_out),
        .sync_mode(sync_mode),
        .sync_master(sync_master)
    );
    // ------------------------------------------------------------
    // bus tasks, comparisons and expectations
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t value %h expected %h", $time, g, e);
        end
    endtask : chk_val
    task automatic chk_cnt(input int g, input int e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t count %0d expected %0d", $time, g, e);
        end
    endtask : chk_cnt
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk_val(reg_rdata, e);
    endtask : rd_chk
    function automatic int exp_per(input logic [7:0] t, input logic [7:0] x);
        return (t[4] ? 4 : (t[2] ? 16 : 64)) * (int'(x) + 1);
    endfunction : exp_per
    // edges until the next sample tick, bounded
    task automatic tick_gap(output int g);
        g = 0;
        do begin
            @(posedge ref_clk);
            #1 g++;
        end while (gen_out.sample_tick !== 1'b1 && g < 20000);
    endtask : tick_gap
    // set mode and divisor, then measure one full spacing
    task automatic rate(input logic [7:0] t, input logic [7:0] x);
        wr(ubrg_pkg::TCS_OFFS, t);
        wr(ubrg_pkg::DIV_OFFS, x);
        tick_gap(c);
        tick_gap(c);
        chk_cnt(c, exp_per(t, x));
    endtask : rate
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        #1000000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd_chk(ubrg_pkg::TCS_OFFS, ubrg_pkg::TCS_RST);
        rd_chk(ubrg_pkg::DIV_OFFS, ubrg_pkg::DIV_RST);
        rd_chk(ubrg_pkg::RCS_OFFS, ubrg_pkg::RCS_RST);
        rd_chk(8'h55, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            tx_shift_empty <= d[0];
            wr(ubrg_pkg::DIV_OFFS, d);
            rd_chk(ubrg_pkg::DIV_OFFS, d);
            wr(ubrg_pkg::TCS_OFFS, d);
            rd_chk(ubrg_pkg::TCS_OFFS, (d & 8'hF5) | {6'h00, d[0], 1'b0});
            wr(ubrg_pkg::RCS_OFFS, d);
            rd_chk(ubrg_pkg::RCS_OFFS, d & 8'hF9);
        end
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            rate(tab[i % 4], 8'($random(seed)) & 8'h0F);
        end
        rate(8'h90, 8'hFF);
        rate(8'h94, 8'hFF);
        rate(8'h84, 8'h00);
        $display("test rates done");
        wr(ubrg_pkg::TCS_OFFS, 8'h10);
        n = 0;
        repeat (400) begin
            @(posedge ref_clk);
            #1 n += int'(gen_out.sample_tick === 1'b1);
        end
        chk_cnt(n, 0);
        wr(ubrg_pkg::TCS_OFFS, 8'h04);
        wr(ubrg_pkg::DIV_OFFS, 8'hC8);
        tick_gap(c);
        repeat (100) @(posedge ref_clk);
        wr(ubrg_pkg::DIV_OFFS, 8'h01);
        tick_gap(c);
        chk_cnt(int'(c <= 36), 1);
        tick_gap(c);
        chk_cnt(c, 32);
        $display("test restart done");
        wr(ubrg_pkg::DIV_OFFS, 8'h00);
        repeat (100) @(posedge ref_clk);
        receive_data_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        receive_data_pin <= 1'b1;
        n = 0;
        repeat (80) begin
            @(posedge ref_clk);
            #1 n += int'(gen_out.rx_level !== 1'b1);
        end
        chk_cnt(n, 0);
        receive_data_pin <= 1'b0;
        repeat (120) @(posedge ref_clk);
        chk_val({7'h00, gen_out.rx_level}, 8'h00);
        receive_data_pin <= 1'b1;
        repeat (120) @(posedge ref_clk);
        chk_val({7'h00, gen_out.rx_level}, 8'h01);
        $display("test vote done");
        tally_and_finish();
    end
endmodule : tb_ubrg_top

/* File: tb/ubrg_chk.sv */
// checker: register port and tick timing of the rate generator
// assumes only the top ports are visible; bound after endmodule
`timescale 1ns/1ps
module ubrg_chk (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // generator outputs
    input wire ubrg_pkg::ubrg_out_s gen_out,
    input wire logic       sync_mode,
    input wire logic       sync_master
);
    // ------------------------------------------------------------
    // shadow registers and tick spacing counter
    // ------------------------------------------------------------
    logic [7:0] div_r;  // shadow divisor
    logic [7:0] tcs_r;  // shadow transmit control
    logic       wr_d_r; // a write other than to RCS landed last cycle
    logic       seen_r; // a clean tick was seen
    int         cnt_r;  // cycles since last tick
    int         per;    // expected tick spacing
    logic       hit;    // write that may restart the timer
    assign hit = reg_wr && reg_addr != ubrg_pkg::RCS_OFFS;
    assign per = (tcs_r[4] ? 4 : (tcs_r[2] ? 16 : 64)) * (int'(div_r) + 1);
    // follow the writes
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            div_r <= ubrg_pkg::DIV_RST;
            tcs_r <= ubrg_pkg::TCS_RST;
        end else if (reg_wr && reg_addr == ubrg_pkg::DIV_OFFS) begin
            div_r <= reg_wdata;
        end else if (reg_wr && reg_addr == ubrg_pkg::TCS_OFFS) begin
            tcs_r <= reg_wdata & ubrg_pkg::TCS_WMASK;
        end
    end
    // count spacing; ignore ticks still in flight after a write
    always_ff @(posedge ref_clk) begin
        wr_d_r <= hit;
        if (!rst_b || hit || wr_d_r) begin
            cnt_r  <= 0;
            seen_r <= 1'b0;
        end else if (gen_out.sample_tick) begin
            cnt_r  <= 0;
            seen_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence clean_tick;
        gen_out.sample_tick && seen_r;
    endsequence
    div_read_a : assert property (
        rd_at(ubrg_pkg::DIV_OFFS) |=> reg_rdata == $past(div_r))
        else $error("divisor read back wrong");
    tcs_read_a : assert property (
        rd_at(ubrg_pkg::TCS_OFFS)
        |=> (reg_rdata & 8'hFD) == ($past(tcs_r) & 8'hFD))
        else $error("transmit control read back wrong");
    mode_out_a : assert property (sync_mode == tcs_r[4])
        else $error("mode output differs from mode bit");
    master_out_a : assert property (
        sync_master == (tcs_r[4] && tcs_r[7]))
        else $error("master output wrong");
    slave_quiet_a : assert property (
        tcs_r[4] && !tcs_r[7] && $past(tcs_r[4] && !tcs_r[7], 2)
        |-> !gen_out.sample_tick && !gen_out.bit_tick)
        else $error("tick produced in slave mode");
    slow_per_a : assert property (
        clean_tick and !tcs_r[4] && !tcs_r[2] |-> cnt_r + 1 == per)
        else $error("slow asynchronous spacing wrong");
    fast_per_a : assert property (
        clean_tick and !tcs_r[4] && tcs_r[2] |-> cnt_r + 1 == per)
        else $error("fast asynchronous spacing wrong");
    sync_per_a : assert property (
        clean_tick and tcs_r[4] |-> cnt_r + 1 == per)
        else $error("synchronous spacing wrong");
    bit_in_smp_a : assert property (
        gen_out.bit_tick |-> gen_out.sample_tick)
        else $error("bit tick without sample tick");
    sync_bit_a : assert property (
        sync_mode && $past(sync_mode)
        |-> gen_out.bit_tick == gen_out.sample_tick)
        else $error("synchronous bit tick differs from sample tick");
endmodule : ubrg_chk

bind ubrg_top ubrg_chk u_chk (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .gen_out(gen_out),
    .sync_mode(sync_mode),
    .sync_master(sync_master)
);
